/* File: src/serial_io_expander_16port.sv */
/*
  16-port serial I/O expander: eight push-pull and eight open-drain
  ports, per-port direction, input change alert and a two-wire target.
  Assumes all pins except srst_in are asynchronous to clock_in and that pad logic
  resolves each pin from its output and output enable.
*/
`timescale 1ns/1ps

module serial_io_expander_16port
  import io_expander_pkg::*;
#(
  parameter logic [3:0][`IOX_PORT_W-1:0] POWERUP_TABLE =
    `IOX_POWERUP_TABLE
)
(
  input wire logic clock_in,                      // 200 MHz clock
  input wire logic srst_in,                       // sync reset, high
  input wire logic scl_in,                        // serial clock pin
  input wire logic sda_in,                        // serial data pin
  output logic sda_out,                           // data drive level
  output logic sda_oe_out,                        // data pull-down
  input wire logic link_reset_n_in,               // link reset, low
  input wire logic addr_sel0_in,                  // address select 0
  input wire logic addr_sel1_in,                  // address select 1
  input wire logic [7:0] pushpull_ports_in,       // push-pull levels
  output logic [7:0] pushpull_ports_out,          // push-pull drive
  output logic [7:0] pushpull_ports_oe_out,       // push-pull enable
  input wire logic [7:0] opendrain_ports_in,      // open-drain levels
  output logic [7:0] opendrain_ports_out,         // open-drain drive
  output logic [7:0] opendrain_ports_oe_out,      // open-drain pull
  output logic change_alert_n_out,                // alert drive level
  output logic change_alert_n_oe_out              // alert pull-down
);

  expander_regs_t r;
  expander_regs_t next_r;
  logic link_rst;
  logic [`IOX_PORT_W-1:0] chg;
  logic [7:0] rd_data;
  logic wr_strobe;
  logic [7:0] wr_data;
  logic [2:0] reg_ptr;
  logic rd_pulse;
  logic link_sda_oe;

  // link held idle until the address straps have been caught
  assign link_rst = srst_in | ~r.lrst_s2 | (r.strap_cnt != 2'h0);

  i2c_target_link u_i2c_target_link
  (
    .clock_in(clock_in),
    .srst_in(link_rst),
    .scl_in(r.scl_s2),
    .sda_in(r.sda_s2),
    .dev_addr_in(r.dev_addr),
    .rd_data_in(rd_data),
    .sda_oe_out(link_sda_oe),
    .wr_strobe_out(wr_strobe),
    .wr_data_out(wr_data),
    .reg_ptr_out(reg_ptr),
    .rd_pulse_out(rd_pulse)
  );

  // changes only count on ports set as inputs, and not while strapping
  assign chg = (r.strap_cnt == 2'h0) ?
    ((r.port_s2 ^ r.port_prev) & r.dir) : '0;

  always_comb
  begin
    unique case (reg_ptr)
      `IOX_REG_IN_LO: rd_data = r.port_s2[7:0];
      `IOX_REG_IN_HI: rd_data = r.port_s2[15:8];
      `IOX_REG_OUT_LO: rd_data = r.out[7:0];
      `IOX_REG_OUT_HI: rd_data = r.out[15:8];
      `IOX_REG_DIR_LO: rd_data = r.dir[7:0];
      `IOX_REG_DIR_HI: rd_data = r.dir[15:8];
      default: rd_data = 8'h00;
    endcase
  end

  always_comb
  begin
    next_r = r;
    next_r.scl_s1 = scl_in;
    next_r.scl_s2 = r.scl_s1;
    next_r.sda_s1 = sda_in;
    next_r.sda_s2 = r.sda_s1;
    next_r.lrst_s1 = link_reset_n_in;
    next_r.lrst_s2 = r.lrst_s1;
    next_r.sel_s1 = {addr_sel1_in, addr_sel0_in};
    next_r.sel_s2 = r.sel_s1;
    next_r.port_s1 = {opendrain_ports_in, pushpull_ports_in};
    next_r.port_s2 = r.port_s1;
    next_r.port_prev = r.port_s2;
    if (r.strap_cnt != 2'h0)
      next_r.strap_cnt = r.strap_cnt - 2'h1;
    if (r.strap_cnt == 2'h1)
    begin
      next_r.dev_addr = {`IOX_ADDR_BASE, r.sel_s2};
      next_r.out = POWERUP_TABLE[r.sel_s2];
    end
    if (wr_strobe)
    begin
      unique case (reg_ptr)
        `IOX_REG_OUT_LO: next_r.out[7:0] = wr_data;
        `IOX_REG_OUT_HI: next_r.out[15:8] = wr_data;
        `IOX_REG_DIR_LO: next_r.dir[7:0] = wr_data;
        `IOX_REG_DIR_HI: next_r.dir[15:8] = wr_data;
        default: ;
      endcase
    end
    // a change in the clearing cycle wins, so no event is lost
    if (|chg)
      next_r.alert = 1'b1;
    else if (rd_pulse)
      next_r.alert = 1'b0;
    next_r.pp_oe = ~next_r.dir[7:0];
    next_r.pp_level = next_r.out[7:0];
    next_r.od_oe = ~next_r.dir[15:8] & ~next_r.out[15:8];
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      r <= '0;
      // both sync stages idle high, so no false edge or link reset follows
      r.scl_s1 <= 1'b1;
      r.scl_s2 <= 1'b1;
      r.sda_s1 <= 1'b1;
      r.sda_s2 <= 1'b1;
      r.lrst_s1 <= 1'b1;
      r.lrst_s2 <= 1'b1;
      r.out <= `IOX_OUT_RESET;
      r.dir <= `IOX_DIR_RESET;
      r.strap_cnt <= `IOX_STRAP_WAIT;
    end
    else
      r <= next_r;
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = link_sda_oe;
  assign pushpull_ports_out = r.pp_level;
  assign pushpull_ports_oe_out = r.pp_oe;
  assign opendrain_ports_out = 8'h00;
  assign opendrain_ports_oe_out = r.od_oe;
  assign change_alert_n_out = 1'b0;
  assign change_alert_n_oe_out = r.alert;

  property p_alert_set;
    @(posedge clock_in) disable iff (srst_in)
      (|chg) |=> change_alert_n_oe_out;
  endproperty
  a_alert_set: assert property (p_alert_set)
    else $error("input change did not raise alert");

  property p_alert_hold;
    @(posedge clock_in) disable iff (srst_in)
      (r.alert && !rd_pulse) |=> r.alert;
  endproperty
  a_alert_hold: assert property (p_alert_hold)
    else $error("alert dropped without a read");

  property p_alert_clear;
    @(posedge clock_in) disable iff (srst_in)
      (rd_pulse && !(|chg)) |=> !change_alert_n_oe_out;
  endproperty
  a_alert_clear: assert property (p_alert_clear)
    else $error("read did not clear alert");

  property p_alert_quiet;
    @(posedge clock_in) disable iff (srst_in)
      (!r.alert && !(|chg)) |=> !change_alert_n_oe_out;
  endproperty
  a_alert_quiet: assert property (p_alert_quiet)
    else $error("alert raised without a change");

  property p_alert_od;
    @(posedge clock_in) disable iff (srst_in)
      change_alert_n_oe_out |-> (change_alert_n_out == 1'b0);
  endproperty
  a_alert_od: assert property (p_alert_od)
    else $error("alert pin driven high");

  property p_pp_dir;
    @(posedge clock_in) disable iff (srst_in)
      wr_strobe && reg_ptr == `IOX_REG_DIR_LO
      |=> ##1 pushpull_ports_oe_out == ~$past(wr_data, 2);
  endproperty
  a_pp_dir: assert property (p_pp_dir)
    else $error("push-pull direction not applied");

  property p_od_drive;
    @(posedge clock_in) disable iff (srst_in)
      opendrain_ports_oe_out == (~r.dir[15:8] & ~r.out[15:8]);
  endproperty
  a_od_drive: assert property (p_od_drive)
    else $error("open-drain enable wrong");

  property p_link_reset;
    @(posedge clock_in) disable iff (srst_in)
      !r.lrst_s2 |=> !sda_oe_out && !rd_pulse && !wr_strobe;
  endproperty
  a_link_reset: assert property (p_link_reset)
    else $error("link active during link reset");

  property p_strap;
    @(posedge clock_in) disable iff (srst_in)
      r.strap_cnt == 2'h1 |=>
      r.dev_addr == {`IOX_ADDR_BASE, $past(r.sel_s2)} &&
      r.out == POWERUP_TABLE[$past(r.sel_s2)];
  endproperty
  a_strap: assert property (p_strap)
    else $error("strap address or power-up level wrong");

endmodule : serial_io_expander_16port

/* File: src/io_expander_consts.svh */
/*
  Constants of the 16-port serial I/O expander: pin widths, internal
  register indices, reset values and link timing figures.
  Assumes inclusion by the package and the bench by bare name.
*/
`ifndef IO_EXPANDER_CONSTS_SVH
`define IO_EXPANDER_CONSTS_SVH

`define IOX_PORT_W 16
`define IOX_HALF_W 8
`define IOX_SEL_W 2

// upper five target address bits; low two come from the select pins
`define IOX_ADDR_BASE 5'h16

// internal register indices, reached through the link pointer
`define IOX_REG_IN_LO 3'h0
`define IOX_REG_IN_HI 3'h1
`define IOX_REG_OUT_LO 3'h2
`define IOX_REG_OUT_HI 3'h3
`define IOX_REG_DIR_LO 3'h4
`define IOX_REG_DIR_HI 3'h5
`define IOX_REG_LAST 3'h5

// direction bit 1 = input; all ports drive their power-up level
`define IOX_DIR_RESET 16'h0000
// outputs high in reset: open-drain ports stay released until straps land
`define IOX_OUT_RESET 16'hFFFF
`define IOX_POWERUP_TABLE 64'h0000_00FF_FF00_FFFF
`define IOX_STRAP_WAIT 2'h3

`define IOX_CLK_KHZ 200000
`define IOX_SCL_MAX_KHZ 400
`define IOX_SCL_MIN_CYC (`IOX_CLK_KHZ / `IOX_SCL_MAX_KHZ)

`endif

/* File: src/io_expander_pkg.sv */
/*
  Types of the 16-port serial I/O expander: link states and the packed
  state records of the link engine and of the port block.
  Assumes io_expander_consts.svh is on the include path.
*/
`include "io_expander_consts.svh"

package io_expander_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX = 3'h1,
    ST_ACK = 3'h2,
    ST_TX = 3'h3,
    ST_TXACK = 3'h4
  } link_state_t;

  typedef enum logic [1:0] {
    PH_ADDR = 2'h0,
    PH_CMD = 2'h1,
    PH_DATA = 2'h2
  } link_phase_t;

  typedef struct packed {
    link_state_t state;
    link_phase_t phase;
    logic [7:0] shreg;
    logic [3:0] cnt;
    logic rw;
    logic [2:0] ptr;
    logic sda_oe;
    logic wr_strobe;
    logic [7:0] wr_data;
    logic rd_pulse;
    logic scl_d;
    logic sda_d;
  } link_regs_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic lrst_s1;
    logic lrst_s2;
    logic [`IOX_SEL_W-1:0] sel_s1;
    logic [`IOX_SEL_W-1:0] sel_s2;
    logic [`IOX_PORT_W-1:0] port_s1;
    logic [`IOX_PORT_W-1:0] port_s2;
    logic [`IOX_PORT_W-1:0] port_prev;
    logic [`IOX_PORT_W-1:0] out;
    logic [`IOX_PORT_W-1:0] dir;
    logic [6:0] dev_addr;
    logic [1:0] strap_cnt;
    logic alert;
    logic [`IOX_HALF_W-1:0] pp_oe;
    logic [`IOX_HALF_W-1:0] pp_level;
    logic [`IOX_HALF_W-1:0] od_oe;
  } expander_regs_t;

endpackage : io_expander_pkg

/* File: src/i2c_target_link.sv */
/*
  Byte-level two-wire target engine: start/stop detection, address
  match, pointer byte, data writes and auto-incrementing reads.
  Assumes scl and sda are already synchronised to clock_in and that
  the caller supplies read data for the current pointer combinationally.
*/
`timescale 1ns/1ps

module i2c_target_link
  import io_expander_pkg::*;
(
  input wire logic clock_in,          // system clock
  input wire logic srst_in,           // sync reset, also link abort
  input wire logic scl_in,            // synchronised serial clock
  input wire logic sda_in,            // synchronised serial data
  input wire logic [6:0] dev_addr_in, // own target address
  input wire logic [7:0] rd_data_in,  // data at current pointer
  output logic sda_oe_out,            // pull data line low
  output logic wr_strobe_out,         // one-cycle write pulse
  output logic [7:0] wr_data_out,     // byte written
  output logic [2:0] reg_ptr_out,     // register pointer
  output logic rd_pulse_out           // one-cycle read-load pulse
);

  link_regs_t r;
  link_regs_t next_r;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic [2:0] ptr_inc;

  assign rise = scl_in & ~r.scl_d;
  assign fall = ~scl_in & r.scl_d;
  assign start = scl_in & r.scl_d & r.sda_d & ~sda_in;
  assign stop = scl_in & r.scl_d & ~r.sda_d & sda_in;
  assign ptr_inc = (r.ptr == `IOX_REG_LAST) ? 3'h0 : r.ptr + 3'h1;

  always_comb
  begin
    next_r = r;
    next_r.wr_strobe = 1'b0;
    next_r.rd_pulse = 1'b0;
    next_r.scl_d = scl_in;
    next_r.sda_d = sda_in;
    if (start)
    begin
      next_r.state = ST_RX;
      next_r.phase = PH_ADDR;
      next_r.cnt = 4'h0;
      next_r.sda_oe = 1'b0;
    end
    else if (stop)
    begin
      next_r.state = ST_IDLE;
      next_r.sda_oe = 1'b0;
    end
    else
    begin
      unique case (r.state)
        ST_IDLE: ;
        ST_RX:
          if (rise)
          begin
            next_r.shreg = {r.shreg[6:0], sda_in};
            next_r.cnt = r.cnt + 4'h1;
          end
          else if (fall && r.cnt == 4'h8)
          begin
            next_r.cnt = 4'h0;
            next_r.state = ST_ACK;
            next_r.sda_oe = 1'b1;
            unique case (r.phase)
              PH_ADDR:
                if (r.shreg[7:1] != dev_addr_in)
                begin
                  next_r.state = ST_IDLE;
                  next_r.sda_oe = 1'b0;
                end
                else
                  next_r.rw = r.shreg[0];
              PH_CMD:
                next_r.ptr = (r.shreg[2:0] > `IOX_REG_LAST) ?
                  3'h0 : r.shreg[2:0];
              PH_DATA:
              begin
                next_r.wr_strobe = 1'b1;
                next_r.wr_data = r.shreg;
              end
              default: next_r.state = ST_IDLE;
            endcase
          end
        ST_ACK:
          if (fall)
          begin
            next_r.sda_oe = 1'b0;
            next_r.state = ST_RX;
            if (r.phase == PH_ADDR && r.rw)
            begin
              next_r.shreg = rd_data_in;
              next_r.sda_oe = ~rd_data_in[7];
              next_r.rd_pulse = 1'b1;
              next_r.state = ST_TX;
            end
            else if (r.phase == PH_DATA)
              next_r.ptr = ptr_inc;
            else if (r.phase == PH_ADDR)
              next_r.phase = PH_CMD;
            else
              next_r.phase = PH_DATA;
          end
        ST_TX:
          if (rise)
            next_r.cnt = r.cnt + 4'h1;
          else if (fall && r.cnt == 4'h8)
          begin
            next_r.sda_oe = 1'b0;
            next_r.cnt = 4'h0;
            next_r.state = ST_TXACK;
          end
          else if (fall)
          begin
            next_r.shreg = {r.shreg[6:0], 1'b0};
            next_r.sda_oe = ~r.shreg[6];
          end
        ST_TXACK:
          if (rise)
          begin
            // controller nack ends the read; wait for stop or start
            if (sda_in)
              next_r.state = ST_IDLE;
            else
              next_r.ptr = ptr_inc;
          end
          else if (fall)
          begin
            next_r.shreg = rd_data_in;
            next_r.sda_oe = ~rd_data_in[7];
            next_r.rd_pulse = 1'b1;
            next_r.state = ST_TX;
          end
        default: next_r.state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      r <= '0;
      r.scl_d <= 1'b1;
      r.sda_d <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign sda_oe_out = r.sda_oe;
  assign wr_strobe_out = r.wr_strobe;
  assign wr_data_out = r.wr_data;
  assign reg_ptr_out = r.ptr;
  assign rd_pulse_out = r.rd_pulse;

endmodule : i2c_target_link

/* File: verif/i2c_host_model.sv */
/*
  Two-wire bus controller model: start, stop, byte writes and reads.
  Assumes the bench resolves the data line from both open-drain drivers.
*/
`timescale 1ns/1ps

module i2c_host_model
(
  input wire logic clock_in,    // bench clock, paces the bus
  input wire logic sda_line_in, // resolved data line
  output logic scl_out,         // serial clock, idles high
  output logic sda_out          // 0 pulls data low, 1 releases
);
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  // bench pace: one scl period is 13 clocks, 65 ns; far above the
  // rated link speed, but every phase still outlasts the resync delay
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock_in);
  endtask : wait_clk

  // scl low on entry and exit; data moves 3 clocks after the fall so
  // the target never sees it change under a high clock
  task automatic bit_cycle(input logic v, output logic seen);
    sda_out <= v;
    wait_clk(4);
    scl_out <= 1'b1;
    wait_clk(6);
    seen = sda_line_in;
    scl_out <= 1'b0;
    wait_clk(3);
  endtask : bit_cycle

  // also serves as repeated start from a low clock
  task automatic start;
    sda_out <= 1'b1;
    wait_clk(4);
    scl_out <= 1'b1;
    wait_clk(6);
    sda_out <= 1'b0;
    wait_clk(6);
    scl_out <= 1'b0;
    wait_clk(3);
  endtask : start

  task automatic stop;
    sda_out <= 1'b0;
    wait_clk(4);
    scl_out <= 1'b1;
    wait_clk(6);
    sda_out <= 1'b1;
    wait_clk(6);
  endtask : stop

  task automatic put_byte(input logic [7:0] b, output logic nack);
    logic seen_bit;
    for (int i = 7; i >= 0; i--)
      bit_cycle(b[i], seen_bit);
    bit_cycle(1'b1, nack);
  endtask : put_byte

  task automatic get_byte(input logic nack, output logic [7:0] b);
    logic seen_bit;
    for (int i = 7; i >= 0; i--)
      bit_cycle(1'b1, b[i]);
    bit_cycle(nack, seen_bit);
  endtask : get_byte
endmodule : i2c_host_model

/* File: verif/serial_io_expander_16port_tb.sv */
/*
  Self-checking bench of the 16-port expander: power-up table, address
  straps, direction writes, change alert and link reset.
  Assumes the controller model and the constants header are available.
*/
`timescale 1ns/1ps
`include "io_expander_consts.svh"

module serial_io_expander_16port_tb;
  import io_expander_pkg::*;
  logic clock_in;
  logic srst_in;
  logic link_reset_n;
  logic [1:0] sel;
  logic [7:0] pp_ext;
  logic [7:0] od_ext;
  logic scl;
  logic host_sda;
  logic sda_line;
  logic sda_drv;
  logic sda_oe;
  logic [7:0] pp_out;
  logic [7:0] pp_oe;
  logic [7:0] od_drv;
  logic [7:0] od_oe;
  logic [7:0] pp_pins;
  logic [7:0] od_pins;
  logic alert_n;
  logic alert_oe;
  int err_total;
  int checks_done;
  localparam logic [63:0] TABLE = `IOX_POWERUP_TABLE;

  // open-drain lines resolve against pull-ups
  assign sda_line = (sda_oe ? sda_drv : 1'b1) & host_sda;
  assign pp_pins = (pp_oe & pp_out) | (~pp_oe & pp_ext);
  assign od_pins = ~od_oe & od_ext;

  serial_io_expander_16port u_serial_io_expander_16port (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .scl_in(scl),
    .sda_in(sda_line),
    .sda_out(sda_drv),
    .sda_oe_out(sda_oe),
    .link_reset_n_in(link_reset_n),
    .addr_sel0_in(sel[0]),
    .addr_sel1_in(sel[1]),
    .pushpull_ports_in(pp_pins),
    .pushpull_ports_out(pp_out),
    .pushpull_ports_oe_out(pp_oe),
    .opendrain_ports_in(od_pins),
    .opendrain_ports_out(od_drv),
    .opendrain_ports_oe_out(od_oe),
    .change_alert_n_out(alert_n),
    .change_alert_n_oe_out(alert_oe)
  );

  i2c_host_model u_i2c_host_model (
    .clock_in(clock_in),
    .sda_line_in(sda_line),
    .scl_out(scl),
    .sda_out(host_sda)
  );

  initial
  begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen,
        exp);
    end
  endtask : check

  task automatic final_report;
    $display("mismatches %0d comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic do_reset(input logic [1:0] s);
    sel <= s;
    srst_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    srst_in <= 1'b0;
    repeat (12) @(posedge clock_in);
  endtask : do_reset

  task automatic write_seq(input logic [2:0] ptr, input logic [31:0] d,
    input int n);
    logic nack;
    u_i2c_host_model.start();
    u_i2c_host_model.put_byte({`IOX_ADDR_BASE, sel, 1'b0}, nack);
    check({7'h00, nack}, 8'h00);
    u_i2c_host_model.put_byte({5'h00, ptr}, nack);
    for (int i = 0; i < n; i++)
      u_i2c_host_model.put_byte(d[31-8*i -: 8], nack);
    u_i2c_host_model.stop();
  endtask : write_seq

  task automatic read_reg(input logic [2:0] ptr, output logic [7:0] d);
    logic nack;
    u_i2c_host_model.start();
    u_i2c_host_model.put_byte({`IOX_ADDR_BASE, sel, 1'b0}, nack);
    u_i2c_host_model.put_byte({5'h00, ptr}, nack);
    u_i2c_host_model.start();
    u_i2c_host_model.put_byte({`IOX_ADDR_BASE, sel, 1'b1}, nack);
    check({7'h00, nack}, 8'h00);
    u_i2c_host_model.get_byte(1'b1, d);
    u_i2c_host_model.stop();
    repeat (6) @(posedge clock_in);
  endtask : read_reg

  task automatic t_powerup_addr;
    logic nack;
    for (int s = 0; s < 4; s++)
    begin
      do_reset(s[1:0]);
      check(pp_out, TABLE[16*s +: 8]);
      check(od_oe, ~TABLE[16*s+8 +: 8]);
      check(pp_oe, 8'hFF);
      u_i2c_host_model.start();
      u_i2c_host_model.put_byte({`IOX_ADDR_BASE, sel, 1'b0}, nack);
      check({7'h00, nack}, 8'h00);
      u_i2c_host_model.stop();
      u_i2c_host_model.start();
      u_i2c_host_model.put_byte({`IOX_ADDR_BASE, ~sel, 1'b0}, nack);
      check({7'h00, nack}, 8'h01);
      u_i2c_host_model.stop();
    end
  endtask : t_powerup_addr

  task automatic t_dir_write;
    logic [7:0] d;
    do_reset(2'h0);
    write_seq(3'h2, 32'hA53C_0FF0, 4);
    repeat (4) @(posedge clock_in);
    check(pp_out, 8'hA5);
    check(pp_oe, 8'hF0);
    check(od_oe, 8'h03);
    check(od_drv, 8'h00);
    check({7'h00, sda_drv}, 8'h00);
    // ports turned input saw their levels move, so the alert is up
    check({7'h00, alert_oe}, 8'h01);
    read_reg(3'h3, d);
    check(d, 8'h3C);
    check({7'h00, alert_oe}, 8'h00);
  endtask : t_dir_write

  task automatic t_alert;
    logic [7:0] d;
    pp_ext <= 8'h06;
    repeat (10) @(posedge clock_in);
    check({7'h00, alert_oe}, 8'h01);
    read_reg(3'h0, d);
    check(d, 8'hA6);
    check({7'h00, alert_oe}, 8'h00);
    // short glitch that is gone before anyone looks
    pp_ext <= 8'h04;
    repeat (2) @(posedge clock_in);
    pp_ext <= 8'h06;
    repeat (10) @(posedge clock_in);
    check({7'h00, alert_oe}, 8'h01);
    check({7'h00, alert_n}, 8'h00);
    read_reg(3'h1, d);
    check(d, 8'hFC);
    check({7'h00, alert_oe}, 8'h00);
    od_ext <= 8'hBF;
    repeat (10) @(posedge clock_in);
    check({7'h00, alert_oe}, 8'h01);
    read_reg(3'h1, d);
    check(d, 8'hBC);
    check({7'h00, alert_oe}, 8'h00);
  endtask : t_alert

  task automatic t_link_reset;
    logic nack;
    logic [7:0] d;
    u_i2c_host_model.start();
    u_i2c_host_model.put_byte({`IOX_ADDR_BASE, sel, 1'b0}, nack);
    u_i2c_host_model.put_byte(8'h04, nack);
    link_reset_n <= 1'b0;
    repeat (10) @(posedge clock_in);
    check({7'h00, sda_oe}, 8'h00);
    link_reset_n <= 1'b1;
    repeat (10) @(posedge clock_in);
    u_i2c_host_model.put_byte(8'h00, nack);
    check({7'h00, nack}, 8'h01);
    u_i2c_host_model.stop();
    check(pp_oe, 8'hF0);
    read_reg(3'h4, d);
    check(d, 8'h0F);
  endtask : t_link_reset

  initial
  begin
    srst_in = 1'b1;
    link_reset_n = 1'b1;
    sel = 2'h0;
    pp_ext = 8'h00;
    od_ext = 8'hFF;
    err_total = 0;
    checks_done = 0;
    t_powerup_addr();
    t_dir_write();
    t_alert();
    t_link_reset();
    final_report();
  end

  // whole run is near 26 us; far past that means a hang
  initial
  begin
    #200000;
    err_total++;
    final_report();
  end
endmodule : serial_io_expander_16port_tb
